// >>> core/ric_consts.svh
// Constants of the remote infrared carrier block: offsets, reset values, timing figures.
// Assumes a 100 MHz core clock and an 8-bit register port with a 3-bit address.
`ifndef RIC_CONSTS_SVH
`define RIC_CONSTS_SVH

`define RIC_ADDR_W 3
`define RIC_OFF_RX_CTRL 3'h0
`define RIC_OFF_TX_CTRL 3'h1
`define RIC_OFF_CONFIG 3'h2
`define RIC_OFF_BANK 3'h3
`define RIC_OFF_FE_SEL 3'h4

`define RIC_RST_RX_CTRL 8'h29
`define RIC_RST_TX_CTRL 8'h69
`define RIC_RST_CONFIG 8'h00
`define RIC_RST_BANK 8'hf4
`define RIC_RST_FE_SEL 8'h00
`define RIC_BANK_READ 8'hf4

`define RIC_CLK_MHZ 100
`define RIC_CLK_KHZ 100000
`define RIC_FREQ_X10_SCALE (`RIC_CLK_KHZ * 10)
`define RIC_MSP_PULSE_US 64
`define RIC_RX_HOLD_US 80

`define RIC_LO_CODE_FIRST 5'h03
`define RIC_LO_FREQ_FIRST_KHZ 30
`define RIC_HI_CODE_A 5'h03
`define RIC_HI_CODE_B 5'h08
`define RIC_HI_CODE_C 5'h0b
`define RIC_HI_FREQ_A_KHZ 400
`define RIC_HI_FREQ_B_KHZ 450
`define RIC_HI_FREQ_C_KHZ 480

`define RIC_PW_LO_2_NS 6000
`define RIC_PW_LO_3_NS 7000
`define RIC_PW_LO_4_NS 9000
`define RIC_PW_LO_5_NS 10600
`define RIC_PW_HI_2_NS 700
`define RIC_PW_HI_3_NS 800
`define RIC_PW_HI_4_NS 900
`define RIC_PW_HI_5_NS 1000

`define RIC_MOD_CONT 2'h0
`define RIC_MOD_BURST8 2'h1
`define RIC_MOD_BURST6 2'h2
`define RIC_BURST8_PULSES 8
`define RIC_BURST6_PULSES 6

`define RIC_MODE_SIR 2'h1
`define RIC_MODE_ASK 2'h2

`endif

// >>> core/ric_pkg.sv
// Types of the remote infrared carrier block: register layouts and transmit states.
// Assumes the constants header is compiled alongside.
package ric_pkg;

  typedef struct packed {
    logic [2:0] rx_band_range;
    logic [4:0] rx_center_freq_code;
  } ric_rx_ctrl_t;

  typedef struct packed {
    logic [2:0] tx_pulse_width_code;
    logic [4:0] tx_carrier_freq_code;
  } ric_tx_ctrl_t;

  typedef struct packed {
    logic pulse_number_coding_en;
    logic rx_sampling_select;
    logic rx_carrier_band;
    logic rsvd;
    logic tx_carrier_band;
    logic rx_decoder_bypass;
    logic [1:0] tx_modulation_pattern;
  } ric_cfg_t;

  typedef struct packed {
    logic front_end_mode_pulse;
    logic [2:0] serial_ir_front_end_code;
    logic rsvd;
    logic [2:0] ask_front_end_code;
  } ric_fe_sel_t;

  typedef enum logic [1:0] {
    RIC_TX_IDLE,
    RIC_TX_BURST,
    RIC_TX_MODE_PULSE
  } ric_tx_state_t;

endpackage

// >>> core/ric_carrier_gen.sv
// Carrier pulse generator: phase accumulator in kHz steps, fixed-width high pulses.
// Assumes freq_khz_i is nonzero and width_i is shorter than one carrier period.
`timescale 1ns/1ps
`default_nettype none
`include "ric_consts.svh"

module ric_carrier_gen (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [8:0] freq_khz_i,
  input wire logic [10:0] width_i,
  output logic carrier_o,
  output logic pulse_start_o
);

  localparam logic [17:0] MOD = 18'(`RIC_CLK_KHZ);

  logic [16:0] acc_reg;
  logic [10:0] wcnt_reg;
  logic [17:0] sum;

  // The accumulator adds the frequency in kHz each cycle, so wraps occur at exactly f.
  assign sum = {1'b0, acc_reg} + {9'h000, freq_khz_i};

  // Parking the phase just below a wrap makes a burst start with a pulse at once.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !run_i) begin
      acc_reg <= 17'(MOD - 18'h1);
      wcnt_reg <= 11'h000;
      carrier_o <= 1'b0;
      pulse_start_o <= 1'b0;
    end else if (sum >= MOD) begin
      acc_reg <= 17'(sum - MOD);
      wcnt_reg <= width_i - 11'h001; // [R6]
      carrier_o <= 1'b1;
      pulse_start_o <= 1'b1;
    end else begin
      acc_reg <= sum[16:0];
      pulse_start_o <= 1'b0;
      if (wcnt_reg != 11'h000) begin
        wcnt_reg <= wcnt_reg - 11'h001;
      end else begin
        carrier_o <= 1'b0;
      end
    end
  end

  // A pulse starts with the count loaded for the programmed width.
  chk_pulse_width: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(pulse_start_o) |-> carrier_o && wcnt_reg == $past(width_i) - 11'h001) // [R6]
    else $error("Carrier pulse width count not loaded.");

endmodule
`default_nettype wire

// >>> core/ric_top.sv
// Remote infrared carrier block: register set, carrier transmitter, band-pass receiver.
// Assumes a single 100 MHz clock; ir_receive_in_i is an asynchronous pin, other inputs
// come from logic on the same clock (baud ticks, mode and auto-format bits).
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "ric_consts.svh"

// Operation
// R1 - Receiver accepts only carriers within the window chosen by range and select codes.
// R2 - Low band: each select code with range 1..3 gives progressively wider windows.
// R3 - High band range 1: codes 3, 8, 11 give their listed acceptance windows.
// R4 - Software programs only listed code combinations; others are reserved.
// R5 - Shift-keyed receiver: range codes 1..6 give widening windows near 500 kHz.
// R6 - Pulse width code 2..5 sets carrier pulse width per band.
// R7 - Low band transmit code 3..29 gives 30..56 kHz in 1 kHz steps.
// R8 - High band transmit codes 3, 8, 11 give 400, 450, 480 kHz.
// R9 - Pulse-number coding: bit 0 means energy, bit 1 means no energy.
// R10 - Sampling bit chooses once-per-period sampling or oversampling with the baud tick.
// R11 - Receive band bit chooses 30..56 kHz or 400..480 kHz.
// R12 - Transmit band bit chooses 30..56 kHz or 400..480 kHz.
// R13 - Decoder bypass bit routes input around the internal decoder.
// R14 - Modulation: continuous, eight or six pulses for an energy bit; none otherwise.
// R15 - Bank select stores a written set number; reads always return f4.
// R16 - Mode pulse bit sends one 64 us pulse on the transmit output.
// R17 - Software uses the mode pulse for front ends switching speed by pin and pulse.
// R18 - Auto format in serial mode drives the serial front-end code onto the pins.
// R19 - Auto format in keyed mode drives the keyed front-end code onto the pins.
// R20 - Reset loads every register of the set with its default value.
module ric_top
  import ric_pkg::*;
#(
  parameter int MSP_PULSE_CYCLES = `RIC_MSP_PULSE_US * `RIC_CLK_MHZ,
  parameter int RX_HOLD_CYCLES = `RIC_RX_HOLD_US * `RIC_CLK_MHZ
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [`RIC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tx_bit_start_i,
  input wire logic tx_bit_i,
  input wire logic ir_receive_in_i,
  input wire logic rx_sample_tick_i,
  input wire logic auto_front_end_format_i,
  input wire logic [1:0] ir_mode_i,
  output logic ir_transmit_out_o,
  output logic rx_data_o,
  output logic rx_carrier_detect_o,
  output logic [2:0] front_end_select_pins_o,
  output logic [7:0] bank_select_o
);

  ric_rx_ctrl_t rx_ctrl_reg;
  ric_tx_ctrl_t tx_ctrl_reg;
  ric_cfg_t cfg_reg;
  ric_fe_sel_t fe_reg;
  ric_tx_state_t tx_state_reg;
  logic [3:0] burst_rem_reg;
  logic [15:0] msp_cnt_reg;
  logic msp_start, tx_energy, gen_carrier, gen_pulse_start;
  logic [3:0] burst_n;
  logic [8:0] tx_freq_khz;
  logic [10:0] tx_width;
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_filt_reg, rx_filt_d_reg;
  logic [15:0] rx_period_reg, rx_hold_reg;
  logic [2:0] rx_hist_reg;
  logic rx_sampled_reg, rx_rise, rx_accept, rx_decoded;
  logic [25:0] rx_win;
  logic [31:0] rx_p;

  // Receive window in 0.1 kHz units, {min, max}; zero means reserved and never accepts.
  function automatic logic [25:0] rx_window(input logic ask, input logic band,
                                            input logic [2:0] rng, input logic [4:0] code);
    logic [77:0] row;
    row = '0;
    rx_window = '0;
    if (ask) begin
      unique case (rng) // [R5]
        3'h1: rx_window = {13'd4800, 13'd5333};
        3'h2: rx_window = {13'd4571, 13'd5647};
        3'h3: rx_window = {13'd4364, 13'd6000};
        3'h4: rx_window = {13'd4174, 13'd6400};
        3'h5: rx_window = {13'd4000, 13'd6856};
        3'h6: rx_window = {13'd3840, 13'd7385};
        default: rx_window = '0;
      endcase
    end else if (band) begin
      if (rng == 3'h1) begin
        unique case (code) // [R3] [R11]
          5'h03: rx_window = {13'd3556, 13'd4571};
          5'h08: rx_window = {13'd3801, 13'd4898};
          5'h0b: rx_window = {13'd4103, 13'd5274};
          default: rx_window = '0;
        endcase
      end
    end else begin
      unique case (code) // [R2] [R11]
        5'h02: row = {13'd261, 13'd296, 13'd247, 13'd317, 13'd234, 13'd342};
        5'h03: row = {13'd282, 13'd320, 13'd267, 13'd343, 13'd253, 13'd369};
        5'h04: row = {13'd294, 13'd333, 13'd278, 13'd357, 13'd263, 13'd384};
        5'h05: row = {13'd300, 13'd340, 13'd284, 13'd365, 13'd269, 13'd393};
        5'h06: row = {13'd314, 13'd356, 13'd296, 13'd381, 13'd281, 13'd410};
        5'h07: row = {13'd321, 13'd364, 13'd303, 13'd390, 13'd287, 13'd420};
        5'h08: row = {13'd328, 13'd372, 13'd310, 13'd398, 13'd294, 13'd429};
        5'h09: row = {13'd336, 13'd381, 13'd317, 13'd408, 13'd301, 13'd440};
        5'h0b: row = {13'd344, 13'd390, 13'd325, 13'd418, 13'd308, 13'd450};
        5'h0c: row = {13'd362, 13'd410, 13'd342, 13'd440, 13'd324, 13'd473};
        5'h0d: row = {13'd372, 13'd421, 13'd351, 13'd451, 13'd332, 13'd486};
        5'h0f: row = {13'd382, 13'd432, 13'd360, 13'd463, 13'd341, 13'd499};
        5'h10: row = {13'd403, 13'd457, 13'd381, 13'd490, 13'd361, 13'd527};
        5'h12: row = {13'd415, 13'd471, 13'd392, 13'd504, 13'd372, 13'd543};
        5'h13: row = {13'd428, 13'd485, 13'd404, 13'd519, 13'd383, 13'd560};
        5'h15: row = {13'd441, 13'd500, 13'd417, 13'd536, 13'd395, 13'd577};
        5'h17: row = {13'd455, 13'd516, 13'd430, 13'd553, 13'd407, 13'd596};
        5'h1a: row = {13'd487, 13'd552, 13'd460, 13'd591, 13'd436, 13'd637};
        5'h1b: row = {13'd504, 13'd571, 13'd476, 13'd612, 13'd451, 13'd659};
        5'h1d: row = {13'd543, 13'd615, 13'd513, 13'd659, 13'd486, 13'd710};
        default: row = '0;
      endcase
      unique case (rng)
        3'h1: rx_window = row[77:52];
        3'h2: rx_window = row[51:26];
        3'h3: rx_window = row[25:0];
        default: rx_window = '0;
      endcase
    end
  endfunction

  // Pulse width in clock cycles; reserved codes fall back to the shortest width.
  function automatic logic [10:0] pw_cycles(input logic band, input logic [2:0] code);
    int ns;
    ns = band ? `RIC_PW_HI_2_NS : `RIC_PW_LO_2_NS;
    unique case (code)
      3'h3: ns = band ? `RIC_PW_HI_3_NS : `RIC_PW_LO_3_NS;
      3'h4: ns = band ? `RIC_PW_HI_4_NS : `RIC_PW_LO_4_NS;
      3'h5: ns = band ? `RIC_PW_HI_5_NS : `RIC_PW_LO_5_NS;
      default: ns = band ? `RIC_PW_HI_2_NS : `RIC_PW_LO_2_NS;
    endcase
    pw_cycles = 11'(ns * `RIC_CLK_MHZ / 1000);
  endfunction

  // Register writes; reserved bits are stored as zero so they read back as zero.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_ctrl_reg <= `RIC_RST_RX_CTRL; // [R20]
      tx_ctrl_reg <= `RIC_RST_TX_CTRL;
      cfg_reg <= `RIC_RST_CONFIG;
      bank_select_o <= `RIC_RST_BANK;
      fe_reg <= `RIC_RST_FE_SEL;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `RIC_OFF_RX_CTRL: rx_ctrl_reg <= reg_wdata_i;
        `RIC_OFF_TX_CTRL: tx_ctrl_reg <= reg_wdata_i;
        `RIC_OFF_CONFIG: cfg_reg <= reg_wdata_i & 8'hef;
        `RIC_OFF_BANK: bank_select_o <= reg_wdata_i; // [R15]
        `RIC_OFF_FE_SEL: fe_reg <= reg_wdata_i & 8'h77;
        default: ;
      endcase
    end
  end

  // Read data appear only in the cycle after the strobe; the bank register is fixed.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      unique case (reg_addr_i)
        `RIC_OFF_RX_CTRL: reg_rdata_o <= rx_ctrl_reg;
        `RIC_OFF_TX_CTRL: reg_rdata_o <= tx_ctrl_reg;
        `RIC_OFF_CONFIG: reg_rdata_o <= cfg_reg;
        `RIC_OFF_BANK: reg_rdata_o <= `RIC_BANK_READ; // [R15]
        `RIC_OFF_FE_SEL: reg_rdata_o <= {tx_state_reg == RIC_TX_MODE_PULSE, fe_reg[6:0]};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Transmit settings decoded from the registers.
  always_comb begin
    tx_width = pw_cycles(cfg_reg.tx_carrier_band, tx_ctrl_reg.tx_pulse_width_code);
    tx_freq_khz = 9'(`RIC_HI_FREQ_A_KHZ);
    if (!cfg_reg.tx_carrier_band) begin
      tx_freq_khz = 9'(`RIC_LO_FREQ_FIRST_KHZ) // [R7] [R12]
                    + {4'h0, tx_ctrl_reg.tx_carrier_freq_code} - {4'h0, `RIC_LO_CODE_FIRST};
    end else if (tx_ctrl_reg.tx_carrier_freq_code == `RIC_HI_CODE_B) begin
      tx_freq_khz = 9'(`RIC_HI_FREQ_B_KHZ); // [R8]
    end else if (tx_ctrl_reg.tx_carrier_freq_code == `RIC_HI_CODE_C) begin
      tx_freq_khz = 9'(`RIC_HI_FREQ_C_KHZ);
    end
    unique case (cfg_reg.tx_modulation_pattern) // [R14]
      `RIC_MOD_BURST8: burst_n = 4'(`RIC_BURST8_PULSES);
      `RIC_MOD_BURST6: burst_n = 4'(`RIC_BURST6_PULSES);
      default: burst_n = 4'h0;
    endcase
  end

  // With coding on an energy bit is a 0; with it off the plain level is taken.
  assign tx_energy = cfg_reg.pulse_number_coding_en ? ~tx_bit_i : tx_bit_i; // [R9]
  assign msp_start = reg_wr_i && reg_addr_i == `RIC_OFF_FE_SEL && reg_wdata_i[7];

  ric_carrier_gen u_gen (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .run_i(tx_state_reg == RIC_TX_BURST),
    .freq_khz_i(tx_freq_khz),
    .width_i(tx_width),
    .carrier_o(gen_carrier),
    .pulse_start_o(gen_pulse_start)
  );

  // Transmit sequencer. A fresh mode-pulse write wins over everything, even a pulse
  // that is ending, so a write of one is never lost.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_state_reg <= RIC_TX_IDLE;
      burst_rem_reg <= 4'h0;
      msp_cnt_reg <= 16'h0000;
    end else if (msp_start) begin
      tx_state_reg <= RIC_TX_MODE_PULSE; // [R16]
      msp_cnt_reg <= 16'(MSP_PULSE_CYCLES - 1);
    end else begin
      unique case (tx_state_reg)
        RIC_TX_IDLE: begin
          if (tx_bit_start_i && tx_energy) begin
            tx_state_reg <= RIC_TX_BURST; // [R14]
            burst_rem_reg <= burst_n;
          end
        end
        RIC_TX_BURST: begin
          if (tx_bit_start_i) begin
            tx_state_reg <= tx_energy ? RIC_TX_BURST : RIC_TX_IDLE; // [R9]
            burst_rem_reg <= burst_n;
          end else if (cfg_reg.tx_modulation_pattern != `RIC_MOD_CONT) begin
            if (gen_pulse_start && burst_rem_reg != 4'h0) begin
              burst_rem_reg <= burst_rem_reg - 4'h1;
            end else if (burst_rem_reg == 4'h0 && !gen_carrier) begin
              tx_state_reg <= RIC_TX_IDLE;
            end
          end
        end
        RIC_TX_MODE_PULSE: begin
          if (msp_cnt_reg == 16'h0000) begin
            tx_state_reg <= RIC_TX_IDLE;
          end else begin
            msp_cnt_reg <= msp_cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  // The mode pulse is a plain level; carrier pulses pass only while a burst runs.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ir_transmit_out_o <= 1'b0;
    end else begin
      ir_transmit_out_o <= (tx_state_reg == RIC_TX_MODE_PULSE) // [R16]
                           || (tx_state_reg == RIC_TX_BURST && gen_carrier);
    end
  end

  // Pin synchroniser; the first stage feeds only the second, and a level is taken
  // once the second and third stages agree.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
      rx_filt_reg <= 1'b0;
      rx_filt_d_reg <= 1'b0;
    end else begin
      rx_s1_reg <= ir_receive_in_i;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg) begin
        rx_filt_reg <= rx_s3_reg;
      end
      rx_filt_d_reg <= rx_filt_reg;
    end
  end

  // Band-pass test by cross-multiplying, which avoids a divider: min <= f <= max with
  // f = scale / period. Reserved windows are all zero and so reject every edge.
  assign rx_rise = rx_filt_reg && !rx_filt_d_reg;
  assign rx_win = rx_window(ir_mode_i == `RIC_MODE_ASK, cfg_reg.rx_carrier_band,
                            rx_ctrl_reg.rx_band_range, rx_ctrl_reg.rx_center_freq_code);
  assign rx_p = {16'h0000, rx_period_reg} + 32'h00000001;
  assign rx_accept = rx_rise && (rx_p * {19'h0, rx_win[25:13]} <= `RIC_FREQ_X10_SCALE)
                     && (rx_p * {19'h0, rx_win[12:0]} >= `RIC_FREQ_X10_SCALE); // [R1] [R4]

  // Period measure and carrier presence hold; a lone edge after quiet is rejected
  // because the counter saturates far below any window.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_period_reg <= 16'hffff;
      rx_hold_reg <= 16'h0000;
      rx_carrier_detect_o <= 1'b0;
    end else begin
      if (rx_rise) begin
        rx_period_reg <= 16'h0000;
      end else if (rx_period_reg != 16'hffff) begin
        rx_period_reg <= rx_period_reg + 16'h0001;
      end
      if (rx_accept) begin
        rx_carrier_detect_o <= 1'b1; // [R1]
        rx_hold_reg <= 16'(RX_HOLD_CYCLES - 1);
      end else if (rx_hold_reg != 16'h0000) begin
        rx_hold_reg <= rx_hold_reg - 16'h0001;
      end else begin
        rx_carrier_detect_o <= 1'b0;
      end
    end
  end

  assign rx_decoded = cfg_reg.pulse_number_coding_en ? ~rx_carrier_detect_o
                                                     : rx_carrier_detect_o; // [R9]

  // Sampling on the baud tick: once per bit, or a majority of three oversamples.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_hist_reg <= 3'h0;
      rx_sampled_reg <= 1'b0;
    end else if (rx_sample_tick_i) begin
      rx_hist_reg <= {rx_hist_reg[1:0], rx_decoded};
      if (cfg_reg.rx_sampling_select) begin
        rx_sampled_reg <= (rx_hist_reg[1] & rx_hist_reg[0]) | // [R10]
                          (rx_hist_reg[1] & rx_decoded) | (rx_hist_reg[0] & rx_decoded);
      end else begin
        rx_sampled_reg <= rx_decoded;
      end
    end
  end

  // Decoder bypass hands the cleaned pin level straight through.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_data_o <= 1'b0;
    end else begin
      rx_data_o <= cfg_reg.rx_decoder_bypass ? rx_filt_reg : rx_sampled_reg; // [R13]
    end
  end

  // Front-end select pins follow the code of the active mode under auto format.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !auto_front_end_format_i) begin
      front_end_select_pins_o <= 3'h0;
    end else if (ir_mode_i == `RIC_MODE_SIR) begin
      front_end_select_pins_o <= fe_reg.serial_ir_front_end_code; // [R18]
    end else if (ir_mode_i == `RIC_MODE_ASK) begin
      front_end_select_pins_o <= fe_reg.ask_front_end_code; // [R19]
    end else begin
      front_end_select_pins_o <= 3'h0;
    end
  end

  sequence s_bank_read;
    reg_rd_i && reg_addr_i == `RIC_OFF_BANK;
  endsequence

  sequence s_msp_write;
    reg_wr_i && reg_addr_i == `RIC_OFF_FE_SEL && reg_wdata_i[7];
  endsequence

  chk_bank_read_fixed: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R15]
    s_bank_read |=> reg_rdata_o == `RIC_BANK_READ)
    else $error("Bank select read did not return f4.");

  chk_reset_defaults: assert property (@(posedge clock_i) // [R20]
    $fell(sys_rst_i) |-> rx_ctrl_reg == `RIC_RST_RX_CTRL && tx_ctrl_reg == `RIC_RST_TX_CTRL
      && bank_select_o == `RIC_RST_BANK && cfg_reg == `RIC_RST_CONFIG)
    else $error("Register default missing after reset.");

  chk_msp_pulse_start: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R16]
    s_msp_write ##1 !reg_wr_i |=> ir_transmit_out_o [*8])
    else $error("Mode pulse did not start on the transmit output.");

  chk_msp_pulse_count: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R16]
    s_msp_write |=> msp_cnt_reg == 16'(MSP_PULSE_CYCLES - 1))
    else $error("Mode pulse length not loaded.");

  chk_burst_limit: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R14]
    tx_state_reg == RIC_TX_BURST && cfg_reg.tx_modulation_pattern != `RIC_MOD_CONT
      |-> burst_rem_reg <= burst_n)
    else $error("Burst pulse count out of range.");

  chk_no_energy_bit: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R9]
    tx_bit_start_i && !tx_energy && !msp_start && tx_state_reg != RIC_TX_MODE_PULSE
      |=> tx_state_reg == RIC_TX_IDLE ##1 !ir_transmit_out_o)
    else $error("Energy sent for a no-energy bit.");

  chk_fe_select_sir: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R18]
    auto_front_end_format_i && ir_mode_i == `RIC_MODE_SIR
      |=> front_end_select_pins_o == $past(fe_reg.serial_ir_front_end_code))
    else $error("Serial front-end code not on select pins.");

  chk_fe_select_ask: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R19]
    auto_front_end_format_i && ir_mode_i == `RIC_MODE_ASK
      |=> front_end_select_pins_o == $past(fe_reg.ask_front_end_code))
    else $error("Keyed front-end code not on select pins.");

  chk_bypass_path: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R13]
    cfg_reg.rx_decoder_bypass |=> rx_data_o == $past(rx_filt_reg))
    else $error("Decoder bypass did not pass the pin level.");

  chk_band_accept: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R1]
    rx_accept |=> rx_carrier_detect_o && rx_hold_reg == 16'(RX_HOLD_CYCLES - 1))
    else $error("Accepted carrier edge not detected.");

  chk_sample_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // [R10]
    !rx_sample_tick_i |=> $stable(rx_sampled_reg))
    else $error("Sample changed without a baud tick.");

endmodule
`default_nettype wire

// >>> bench/ric_front_end_model.sv
// Infrared front-end model: lights the receive pin with a carrier, times transmit pulses.
// Assumes the block's clock; a period of 0 keeps the receive pin dark.
`timescale 1ns/1ps
`default_nettype none
module ric_front_end_model (
  input wire logic clock_i,
  input var int rx_period_i,
  input wire logic ir_transmit_out_i,
  output logic ir_receive_out_o,
  output int tx_pulses_o,
  output int tx_width_o
);
  int phase;
  int run;
  logic tx_last;
  // Quarter-period light bursts, as a photodiode stage passes them on.
  always @(posedge clock_i) begin
    phase <= (rx_period_i == 0 || phase >= rx_period_i - 1) ? 0 : phase + 1;
    ir_receive_out_o <= (rx_period_i != 0) && (phase < rx_period_i / 4);
  end
  // A pulse is counted at its falling edge, so a stuck-high output never counts.
  always @(posedge clock_i) begin
    tx_last <= ir_transmit_out_i;
    run <= ir_transmit_out_i ? run + 1 : 0;
    if (tx_last && !ir_transmit_out_i) begin
      tx_pulses_o <= tx_pulses_o + 1;
      tx_width_o <= run;
    end
  end
endmodule
`default_nettype wire

// >>> bench/remote_ir_carrier_config_tb.sv
// Self-checking bench of the remote infrared carrier block with a front-end model.
// Assumes a shortened mode-pulse count and a lengthened hold count; read results are queued and compared.
`timescale 1ns/1ps
`default_nettype none
`include "ric_consts.svh"
module remote_ir_carrier_config_tb;
  import ric_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic start = 1'b0;
  logic bit_v = 1'b1;
  logic tick = 1'b0;
  logic auto_fmt = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] rdata, bank, v;
  logic [2:0] pins;
  logic tx_out, rx_pin, detect, rx_data;
  int rx_period = 0;
  int pulses, width, p0, error_cnt = 0, comparisons = 0, cycles = 0, seed = 66028;
  logic [7:0] exp_q[$];
  logic [7:0] rst_v[6] = '{8'h29, 8'h69, 8'h00, 8'hf4, 8'h00, 8'h00};
  logic [7:0] tx_cfg[2] = '{8'h09, 8'h02};
  logic [7:0] tx_ctl[2] = '{8'h8b, 8'hbd};
  int tx_n[2] = '{8, 6};
  int tx_w[2] = '{90, 1060};
  ric_top #(.MSP_PULSE_CYCLES(20), .RX_HOLD_CYCLES(9000)) u_ric_top (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .tx_bit_start_i(start), .tx_bit_i(bit_v),
    .ir_receive_in_i(rx_pin), .rx_sample_tick_i(tick), .auto_front_end_format_i(auto_fmt),
    .ir_mode_i(mode), .ir_transmit_out_o(tx_out), .rx_data_o(rx_data),
    .rx_carrier_detect_o(detect), .front_end_select_pins_o(pins), .bank_select_o(bank));
  ric_front_end_model u_ric_front_end_model (.clock_i(clock_i), .rx_period_i(rx_period),
    .ir_transmit_out_i(tx_out), .ir_receive_out_o(rx_pin), .tx_pulses_o(pulses),
    .tx_width_o(width));
  // Free-running clock.
  always #5 clock_i = ~clock_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clock_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Baud tick and a hang guard; the ceiling leaves margin over the longest waits.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    tick <= (cycles % 64 == 0);
    if (cycles == 80000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge clock_i) begin
    rd_d <= rd;
    if (rd_d) check(rdata, exp_q.pop_front(), "read data");
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) bus(1'b0, i[2:0], rst_v[i]);
    bus(1'b1, 3'h3, 8'h07);
    @(posedge clock_i);
    check(bank, 8'h07, "bank");
    bus(1'b0, 3'h3, 8'hf4);
    auto_fmt <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      v = 8'($random(seed)) & 8'h77;
      bus(1'b1, 3'h4, v);
      for (int m = 0; m < 3; m++) begin
        mode <= m[1:0];
        repeat (3) @(posedge clock_i);
        check(pins, m == 1 ? v[6:4] : m == 2 ? v[2:0] : 3'h0, "pins");
      end
      bus(1'b0, 3'h4, v);
    end
    mode <= 2'h0;
    p0 = pulses;
    bus(1'b1, 3'h4, 8'h80);
    bus(1'b0, 3'h4, 8'h80);
    repeat (30) @(posedge clock_i);
    check(width, 20, "mode pulse");
    check(pulses - p0, 1, "mode pulse count");
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 3'h2, tx_cfg[i]);
      bus(1'b1, 3'h1, tx_ctl[i]);
      p0 = pulses;
      start <= 1'b1;
      @(posedge clock_i);
      start <= 1'b0;
      repeat (12000) @(posedge clock_i);
      check(pulses - p0, tx_n[i], "burst count");
      check(width, tx_w[i], "pulse width");
    end
    // Coding on: a 0 bit carries energy, a 1 bit stops the continuous train.
    bus(1'b1, 3'h2, 8'h80);
    bit_v <= 1'b0;
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    p0 = pulses;
    repeat (5000) @(posedge clock_i);
    check(pulses - p0, 3, "continuous pulses");
    bit_v <= 1'b1;
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    repeat (10) @(posedge clock_i);
    p0 = pulses;
    repeat (4000) @(posedge clock_i);
    check(pulses - p0, 0, "no energy bit");
    rx_period <= 2778;
    repeat (11200) @(posedge clock_i);
    check(detect, 1'b1, "detect in band");
    check(rx_data, 1'b0, "coded data energy");
    rx_period <= 4000;
    repeat (17000) @(posedge clock_i);
    check(detect, 1'b0, "detect out of band");
    check(rx_data, 1'b1, "coded data quiet");
    // A dark pin reads 0 through the bypass but 1 through the coded decoder.
    rx_period <= 0;
    bus(1'b1, 3'h2, 8'h84);
    repeat (20) @(posedge clock_i);
    check(rx_data, 1'b0, "decoder bypass");
    bus(1'b1, 3'h2, 8'hc0);
    repeat (200) @(posedge clock_i);
    check(rx_data, 1'b1, "oversampled data");
    wrap_up();
  end
endmodule
`default_nettype wire
